// ---- pkg/smpc_defines.svh ----
// Offsets, fields, reset values and timing counts of the pin block.
`ifndef SMPC_DEFINES_SVH
`define SMPC_DEFINES_SVH

// Register byte offsets on the APB.
`define SMPC_OFF_CTRL 8'h00
`define SMPC_OFF_FLAG_DIR 8'h04
`define SMPC_OFF_FLAG_OUT 8'h08
`define SMPC_OFF_FLAG_IN 8'h0c
`define SMPC_OFF_MODE 8'h10
`define SMPC_OFF_IRQ_STAT 8'h14
`define SMPC_OFF_IRQ_MASK 8'h18
`define SMPC_OFF_EXT_ADDR 8'h1c
`define SMPC_OFF_EXT_WDATA 8'h20
`define SMPC_OFF_EXT_CMD 8'h24
`define SMPC_OFF_EXT_RDATA 8'h28

// Control register fields.
`define SMPC_CTRL_SP1_ALT 0
`define SMPC_CTRL_CONFIG_IRQ_IN_2_EDGE 1
`define SMPC_CTRL_IRQ0_EDGE 2
`define SMPC_CTRL_IRQ1_EDGE 3
`define SMPC_CTRL_ALT_FO 4
`define SMPC_CTRL_CMS_LO 5
`define SMPC_CTRL_W 9
`define SMPC_CTRL_RST 9'h060

// Interrupt status and mask bit positions.
`define SMPC_IRQ_CFG2 0
`define SMPC_IRQ_LVL1 1
`define SMPC_IRQ_LVL0 2
`define SMPC_IRQ_EDGE 3
`define SMPC_IRQ_ALT1 4
`define SMPC_IRQ_ALT0 5
`define SMPC_IRQ_W 6
`define SMPC_INTERRUPT_MASK_BITS_RST 6'h00

// Second serial port pin indices.
`define SMPC_SP_SCLK 0
`define SMPC_SP_DR 1
`define SMPC_SP_RFS 2
`define SMPC_SP_TFS 3
`define SMPC_SP_DT 4

// External access command fields.
`define SMPC_CMD_WRITE 2
`define SMPC_CMD_BUSY 0

// Timing: clock period and least memory strobe width.
`define SMPC_CLK_PS 5000
`define SMPC_STROBE_NS 12

// Host port buffer size.
`define SMPC_HP_AW 4
`define SMPC_HP_DEPTH 16

`endif

// ---- pkg/smpc_pkg.sv ----
// Types shared by the strap and pin configuration block.
`include "smpc_defines.svh"
package smpc_pkg;

    // External access sequencer states, Gray coded along the path.
    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_SETUP = 2'b01,
        XF_STROBE = 2'b11,
        XF_HOLD = 2'b10
    } smpc_xfer_e;

    // Memory space of an external access.
    typedef enum logic [1:0] {
        SP_DATA = 2'b00,
        SP_PROG = 2'b01,
        SP_IO = 2'b10,
        SP_BYTE = 2'b11
    } smpc_space_e;

    // Select strobes, all active low.
    typedef struct packed {
        logic dms_n;
        logic pms_n;
        logic io_space_select_n;
        logic bms_n;
        logic cms_n;
    } smpc_sel_s;

    // State of one shared flag and interrupt pin.
    typedef struct packed {
        logic out;
        logic oe;
        logic prev;
        logic req;
    } smpc_pin_s;

    // State of the host port.
    typedef struct packed {
        logic [`SMPC_HP_DEPTH-1:0][15:0] mem;
        logic [`SMPC_HP_AW-1:0] addr;
        logic wr_q;
        logic rd_q;
        logic ack_n;
        logic ad_oe;
        logic [15:0] ad_out;
    } smpc_hp_s;

    // State of the top block.
    typedef struct packed {
        logic cap_done;
        logic [2:0] straps;
        logic host_mode;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [`SMPC_CTRL_W-1:0] ctrl;
        logic [7:0] fdir;
        logic [10:0] fout;
        logic [`SMPC_IRQ_W-1:0] istat;
        logic [`SMPC_IRQ_W-1:0] interrupt_mask_bits;
        logic irq;
        logic [`SMPC_IRQ_W-1:0] ipend;
        logic [21:0] xaddr;
        logic [23:0] xwdata;
        logic [2:0] xcmd;
        logic [23:0] xrdata;
        smpc_xfer_e xst;
        logic [7:0] xcnt;
        logic [13:0] abus;
        logic [23:0] dout;
        logic [23:0] doe;
        smpc_sel_s sel;
        logic rd_n;
        logic wr_n;
        logic [4:0] sp_out;
        logic [4:0] sp_oe;
        logic [4:0] sp_core_in;
    } smpc_top_s;

endpackage : smpc_pkg

// ---- rtl/smpc_flag_pin.sv ----
// One programmable flag pin with its shared interrupt request detector.
`timescale 1ns/1ps
module smpc_flag_pin (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pad side
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // Control side
    input wire logic run,
    input wire logic dir,
    input wire logic out_val,
    input wire logic edge_sel,
    output logic level,
    output logic irq_req
);
    import smpc_pkg::*;

    smpc_pin_s st_r;
    smpc_pin_s st_nxt;

    // Level includes own drive, so a flag driven low interrupts.
    assign level = st_r.oe ? st_r.out : pin_in;
    assign pin_out = st_r.out;
    assign pin_oe = st_r.oe;
    assign irq_req = st_r.req;

    // Drive after strap capture; request on low level or fall.
    always_comb begin
        st_nxt = st_r;
        st_nxt.out = out_val;
        st_nxt.oe = run & dir;
        st_nxt.prev = level;
        st_nxt.req = edge_sel ? (st_r.prev & ~level) : ~level;
    end

    // Pin state register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{out: 1'b0, oe: 1'b0, prev: 1'b1, req: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : smpc_flag_pin

// ---- rtl/smpc_host_port.sv ----
// Host side address/data port into a small on-chip buffer, live only in host mode.
`timescale 1ns/1ps
module smpc_host_port (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode
    input wire logic enable,
    // Host pins
    input wire logic [15:0] ad_in,
    output logic [15:0] ad_out,
    output logic ad_oe,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic addr_latch,
    input wire logic sel_n,
    output logic ack_n
);
    import smpc_pkg::*;

    smpc_hp_s st_r;
    smpc_hp_s st_nxt;
    logic sel;

    assign sel = enable & ~sel_n;
    assign ad_out = st_r.ad_out;
    assign ad_oe = st_r.ad_oe;
    assign ack_n = st_r.ack_n;

    // Latch address, write, step address, drive read data.
    always_comb begin
        st_nxt = st_r;
        st_nxt.wr_q = sel & ~wr_n;
        st_nxt.rd_q = sel & ~rd_n;
        if (sel && addr_latch) begin
            st_nxt.addr = ad_in[`SMPC_HP_AW-1:0];
        end else if (sel && !wr_n && !st_r.wr_q) begin
            st_nxt.mem[st_r.addr] = ad_in;
        end else if ((st_r.wr_q && wr_n) || (st_r.rd_q && rd_n)) begin
            st_nxt.addr = st_r.addr + 1'b1;
        end
        st_nxt.ad_out = st_r.mem[st_r.addr];
        st_nxt.ad_oe = sel & ~rd_n;
        st_nxt.ack_n = ~(sel & (~wr_n | ~rd_n));
    end

    // Port state; reset clears the buffer.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{ack_n: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : smpc_host_port

// ---- rtl/smpc_top.sv ----
// Strap capture, mode pin routing, flag/interrupt pins and memory select strobes.
`timescale 1ns/1ps
`include "smpc_defines.svh"

// What this block does
// - Straps read once, at the first clock after reset; then flag pins.
// - Mode fixed by host strap at the first clock after reset.
// - Strap low: full memory mode; high: host mode.
// - Full mode: 14 address, 24 data bits, byte address high.
// - Host mode: 16-bit host port, address bit 0, upper data.
// - Host drives port strobes; device answers on acknowledge.
// - Low select per space, combined select, read, write.
// - Shared pins keep flag and interrupt; own drive interrupts.
// - Software switches serial pins to interrupts and flags.
// - Bus pins set at reset; serial pins any time.
module smpc_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Programmable flag pins; 0..2 are the straps, 4..7 carry interrupts
    input wire logic [7:0] prog_flag_in,
    output logic [7:0] prog_flag_out,
    output logic [7:0] prog_flag_oe,
    output logic [2:0] fixed_output_flags,
    // Second serial port pads and serial core
    input wire logic [4:0] second_serial_port_in,
    output logic [4:0] second_serial_port_out,
    output logic [4:0] second_serial_port_oe,
    input wire logic [4:0] sp_core_out,
    input wire logic [4:0] sp_core_oe,
    output logic [4:0] sp_core_in,
    // External memory bus
    output logic [13:0] ext_address_bus,
    input wire logic [23:0] ext_data_bus_in,
    output logic [23:0] ext_data_bus_out,
    output logic [23:0] ext_data_bus_oe,
    output smpc_pkg::smpc_sel_s space_select_n,
    output logic mem_rd_n,
    output logic mem_wr_n,
    // Host port
    input wire logic [15:0] host_port_addr_data_in,
    output logic [15:0] host_port_addr_data_out,
    output logic [15:0] host_port_addr_data_oe,
    input wire logic host_port_write_en_n,
    input wire logic host_port_read_en_n,
    input wire logic host_port_addr_latch,
    input wire logic host_port_select_n,
    output logic host_port_ack_n,
    // Mode and interrupts
    output logic host_mode,
    output logic [5:0] irq_pending,
    output logic irq
);
    import smpc_pkg::*;

    // Strobe width rounds up to whole cycles, at least one.
    localparam int STROBE_RAW = (`SMPC_STROBE_NS * 1000 + `SMPC_CLK_PS - 1) / `SMPC_CLK_PS;
    localparam int STROBE_CYC = (STROBE_RAW < 1) ? 1 : STROBE_RAW;
    localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);

    localparam smpc_top_s TOP_RST = '{
        ctrl: `SMPC_CTRL_RST, interrupt_mask_bits: `SMPC_INTERRUPT_MASK_BITS_RST,
        xst: XF_IDLE,
        sel: 5'h1f, rd_n: 1'b1, wr_n: 1'b1,
        default: '0
    };

    smpc_top_s st_r;
    smpc_top_s st_nxt;

    logic [7:0] pf_level;
    logic [7:0] pf_req;
    logic alt0_req;
    logic alt1_req;
    logic [7:0] pf_edge;
    logic apb_setup;
    logic apb_done;
    logic [5:0] irq_events;
    logic hp_ad_oe;

    // Strap pins stay released until capture.
    always_comb begin
        pf_edge = 8'h00;
        pf_edge[4] = 1'b1;
        pf_edge[7] = st_r.ctrl[`SMPC_CTRL_CONFIG_IRQ_IN_2_EDGE];
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            smpc_flag_pin u_pin (
                .clk(pclk),
                .rst_n(presetn),
                .pin_in(prog_flag_in[gi]),
                .pin_out(prog_flag_out[gi]),
                .pin_oe(prog_flag_oe[gi]),
                .run(st_r.cap_done),
                .dir(st_r.fdir[gi]),
                .out_val(st_r.fout[gi]),
                .edge_sel(pf_edge[gi]),
                .level(pf_level[gi]),
                .irq_req(pf_req[gi])
            );
        end
    endgenerate

    // Serial frame pins as interrupt inputs, never driven.
    smpc_flag_pin u_alt_irq0 (
        .clk(pclk),
        .rst_n(presetn),
        .pin_in(second_serial_port_in[`SMPC_SP_RFS]),
        .pin_out(),
        .pin_oe(),
        .run(1'b0),
        .dir(1'b0),
        .out_val(1'b0),
        .edge_sel(st_r.ctrl[`SMPC_CTRL_IRQ0_EDGE]),
        .level(),
        .irq_req(alt0_req)
    );

    smpc_flag_pin u_alt_irq1 (
        .clk(pclk),
        .rst_n(presetn),
        .pin_in(second_serial_port_in[`SMPC_SP_TFS]),
        .pin_out(),
        .pin_oe(),
        .run(1'b0),
        .dir(1'b0),
        .out_val(1'b0),
        .edge_sel(st_r.ctrl[`SMPC_CTRL_IRQ1_EDGE]),
        .level(),
        .irq_req(alt1_req)
    );

    // Host port; deaf outside host mode.
    smpc_host_port u_host (
        .clk(pclk),
        .rst_n(presetn),
        .enable(st_r.host_mode),
        .ad_in(host_port_addr_data_in),
        .ad_out(host_port_addr_data_out),
        .ad_oe(hp_ad_oe),
        .wr_n(host_port_write_en_n),
        .rd_n(host_port_read_en_n),
        .addr_latch(host_port_addr_latch),
        .sel_n(host_port_select_n),
        .ack_n(host_port_ack_n)
    );

    assign host_port_addr_data_oe = {16{hp_ad_oe}};

    // Answer prepared in setup, done in first access cycle.
    assign apb_setup = psel & ~penable;
    assign apb_done = psel & penable & st_r.pready;

    always_comb begin
        irq_events = 6'h00;
        irq_events[`SMPC_IRQ_CFG2] = pf_req[7];
        irq_events[`SMPC_IRQ_LVL1] = pf_req[6];
        irq_events[`SMPC_IRQ_LVL0] = pf_req[5];
        irq_events[`SMPC_IRQ_EDGE] = pf_req[4];
        irq_events[`SMPC_IRQ_ALT1] = alt1_req & st_r.ctrl[`SMPC_CTRL_SP1_ALT];
        irq_events[`SMPC_IRQ_ALT0] = alt0_req & st_r.ctrl[`SMPC_CTRL_SP1_ALT];
    end

    // Next-state function.
    always_comb begin
        st_nxt = st_r;

        if (!st_r.cap_done) begin
            st_nxt.cap_done = 1'b1;
            st_nxt.straps = prog_flag_in[2:0];
            st_nxt.host_mode = prog_flag_in[2];
        end

        // Read data prepared in setup.
        st_nxt.pready = apb_setup;
        if (apb_setup) begin
            st_nxt.prdata = 32'h0;
            st_nxt.pslverr = 1'b0;
            if (paddr == `SMPC_OFF_CTRL) begin
                st_nxt.prdata[`SMPC_CTRL_W-1:0] = st_r.ctrl;
            end else if (paddr == `SMPC_OFF_FLAG_DIR) begin
                st_nxt.prdata[7:0] = st_r.fdir;
            end else if (paddr == `SMPC_OFF_FLAG_OUT) begin
                st_nxt.prdata[10:0] = st_r.fout;
            end else if (paddr == `SMPC_OFF_FLAG_IN) begin
                st_nxt.prdata[8:0] = {second_serial_port_in[`SMPC_SP_DR], pf_level};
            end else if (paddr == `SMPC_OFF_MODE) begin
                st_nxt.prdata[3:0] = {st_r.host_mode, st_r.straps};
            end else if (paddr == `SMPC_OFF_IRQ_STAT) begin
                st_nxt.prdata[5:0] = st_r.istat | irq_events;
            end else if (paddr == `SMPC_OFF_IRQ_MASK) begin
                st_nxt.prdata[5:0] = st_r.interrupt_mask_bits;
            end else if (paddr == `SMPC_OFF_EXT_ADDR) begin
                st_nxt.prdata[21:0] = st_r.xaddr;
            end else if (paddr == `SMPC_OFF_EXT_WDATA) begin
                st_nxt.prdata[23:0] = st_r.xwdata;
            end else if (paddr == `SMPC_OFF_EXT_CMD) begin
                st_nxt.prdata[`SMPC_CMD_BUSY] = (st_r.xst != XF_IDLE);
            end else if (paddr == `SMPC_OFF_EXT_RDATA) begin
                st_nxt.prdata[23:0] = st_r.xrdata;
            end else begin
                st_nxt.pslverr = 1'b1;
            end
        end

        // Writes land at the completing edge.
        if (apb_done && pwrite) begin
            if (paddr == `SMPC_OFF_CTRL) begin
                st_nxt.ctrl = pwdata[`SMPC_CTRL_W-1:0];
            end else if (paddr == `SMPC_OFF_FLAG_DIR) begin
                st_nxt.fdir = pwdata[7:0];
            end else if (paddr == `SMPC_OFF_FLAG_OUT) begin
                st_nxt.fout = pwdata[10:0];
            end else if (paddr == `SMPC_OFF_IRQ_MASK) begin
                st_nxt.interrupt_mask_bits = pwdata[5:0];
            end else if (paddr == `SMPC_OFF_EXT_ADDR) begin
                st_nxt.xaddr = pwdata[21:0];
            end else if (paddr == `SMPC_OFF_EXT_WDATA) begin
                st_nxt.xwdata = pwdata[23:0];
            end else if (paddr == `SMPC_OFF_EXT_CMD && st_r.xst == XF_IDLE) begin
                // Busy: command dropped to protect the live access.
                st_nxt.xcmd = pwdata[2:0];
                st_nxt.xst = XF_SETUP;
            end
        end

        // Sticky status; read clears, same-cycle event wins.
        if (apb_done && !pwrite && paddr == `SMPC_OFF_IRQ_STAT) begin
            st_nxt.istat = irq_events;
        end else begin
            st_nxt.istat = st_r.istat | irq_events;
        end
        st_nxt.ipend = st_nxt.istat & st_nxt.interrupt_mask_bits;
        st_nxt.irq = |(st_nxt.istat & st_nxt.interrupt_mask_bits);

        // Access sequencer.
        case (st_r.xst)
            XF_SETUP: begin
                // Host mode keeps bit 0 and upper data.
                if (st_r.host_mode) begin
                    st_nxt.abus = {13'h0, st_r.xaddr[0]};
                    st_nxt.dout = {st_r.xwdata[23:8], 8'h00};
                    st_nxt.doe = st_r.xcmd[`SMPC_CMD_WRITE] ? 24'hffff00 : 24'h0;
                end else if (smpc_space_e'(st_r.xcmd[1:0]) == SP_BYTE) begin
                    st_nxt.abus = st_r.xaddr[13:0];
                    st_nxt.dout = {st_r.xaddr[21:14], st_r.xwdata[15:0]};
                    st_nxt.doe = st_r.xcmd[`SMPC_CMD_WRITE] ? 24'hffffff : 24'hff0000;
                end else begin
                    st_nxt.abus = st_r.xaddr[13:0];
                    st_nxt.dout = st_r.xwdata;
                    st_nxt.doe = st_r.xcmd[`SMPC_CMD_WRITE] ? 24'hffffff : 24'h0;
                end
                st_nxt.xcnt = 8'h00;
                st_nxt.xst = XF_STROBE;
            end
            XF_STROBE: begin
                st_nxt.sel.dms_n = ~(smpc_space_e'(st_r.xcmd[1:0]) == SP_DATA);
                st_nxt.sel.pms_n = ~(smpc_space_e'(st_r.xcmd[1:0]) == SP_PROG);
                st_nxt.sel.io_space_select_n = ~(smpc_space_e'(st_r.xcmd[1:0]) == SP_IO);
                st_nxt.sel.bms_n = ~(smpc_space_e'(st_r.xcmd[1:0]) == SP_BYTE);
                st_nxt.sel.cms_n = ~st_r.ctrl[`SMPC_CTRL_CMS_LO + 32'(st_r.xcmd[1:0])];
                st_nxt.rd_n = st_r.xcmd[`SMPC_CMD_WRITE];
                st_nxt.wr_n = ~st_r.xcmd[`SMPC_CMD_WRITE];
                if (st_r.xcnt == STROBE_LAST) begin
                    st_nxt.xst = XF_HOLD;
                end else begin
                    st_nxt.xcnt = st_r.xcnt + 8'h01;
                end
            end
            XF_HOLD: begin
                // Strobes rise a cycle before data drive drops; address holds.
                st_nxt.sel = 5'h1f;
                st_nxt.rd_n = 1'b1;
                st_nxt.wr_n = 1'b1;
                if (!st_r.xcmd[`SMPC_CMD_WRITE]) begin
                    st_nxt.xrdata = st_r.host_mode ? {ext_data_bus_in[23:8], 8'h00} : ext_data_bus_in;
                end
                st_nxt.xst = XF_IDLE;
            end
            default: begin
                st_nxt.doe = 24'h0;
            end
        endcase

        if (st_r.ctrl[`SMPC_CTRL_SP1_ALT]) begin
            st_nxt.sp_out = {st_r.ctrl[`SMPC_CTRL_ALT_FO], 3'h0, sp_core_out[`SMPC_SP_SCLK]};
            st_nxt.sp_oe = {1'b1, 3'h0, sp_core_oe[`SMPC_SP_SCLK]};
            st_nxt.sp_core_in = {4'h0, second_serial_port_in[`SMPC_SP_SCLK]};
        end else begin
            st_nxt.sp_out = sp_core_out;
            st_nxt.sp_oe = sp_core_oe;
            st_nxt.sp_core_in = second_serial_port_in;
        end
    end

    // Reset: strobes high, pads released.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= TOP_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs from the state register.
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign fixed_output_flags = st_r.fout[10:8];
    assign second_serial_port_out = st_r.sp_out;
    assign second_serial_port_oe = st_r.sp_oe;
    assign sp_core_in = st_r.sp_core_in;
    assign ext_address_bus = st_r.abus;
    assign ext_data_bus_out = st_r.dout;
    assign ext_data_bus_oe = st_r.doe;
    assign space_select_n = st_r.sel;
    assign mem_rd_n = st_r.rd_n;
    assign mem_wr_n = st_r.wr_n;
    assign host_mode = st_r.host_mode;
    assign irq_pending = st_r.ipend;
    assign irq = st_r.irq;

endmodule : smpc_top

// ---- sim/smpc_top_props.sv ----
// Checker of the mode, strobe, flag and host port pins.
`timescale 1ns/1ps
module smpc_top_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Observed outputs
    input wire logic host_mode,
    input wire logic [7:0] prog_flag_oe,
    input wire logic [13:0] ext_address_bus,
    input wire logic [23:0] ext_data_bus_oe,
    input wire logic [15:0] host_port_addr_data_oe,
    input wire logic host_port_ack_n,
    input smpc_pkg::smpc_sel_s space_select_n,
    input wire logic mem_rd_n,
    input wire logic mem_wr_n,
    input wire logic [5:0] irq_pending,
    input wire logic irq,
    // Host strobes
    input wire logic host_port_select_n,
    input wire logic host_port_write_en_n,
    input wire logic host_port_read_en_n
);
    import smpc_pkg::*;
    // Bus clock; off in reset.
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_mode_fixed: assert property ($past(presetn, 2) |-> $stable(host_mode))
        else $error("mode moved while running");
    chk_flags_quiet: assert property (!$past(presetn) |-> prog_flag_oe == 8'h00)
        else $error("flag driven at reset release");
    chk_host_pins: assert property (host_mode |-> ext_address_bus[13:1] == 13'h0000 && ext_data_bus_oe[7:0] == 8'h00)
        else $error("host mode uses full bus");
    chk_full_port: assert property (!host_mode |-> host_port_addr_data_oe == 16'h0000 && host_port_ack_n)
        else $error("host port live in full mode");
    chk_one_select: assert property ($onehot0(~space_select_n[4:1]))
        else $error("two space selects low");
    chk_strobe_sel: assert property (!mem_rd_n || !mem_wr_n |-> mem_rd_n != mem_wr_n && !(&space_select_n[4:1]))
        else $error("strobe without single select");
    chk_strobe_width: assert property ($fell(mem_wr_n) |-> !mem_wr_n [*3] ##1 mem_wr_n)
        else $error("write strobe width wrong");
    chk_irq_level: assert property (irq == |irq_pending)
        else $error("irq does not follow pending");
    chk_ack_cause: assert property ($fell(host_port_ack_n) |->
        $past(!host_port_select_n && !(host_port_write_en_n && host_port_read_en_n)))
        else $error("ack without host strobe");
endmodule : smpc_top_props

bind smpc_top smpc_top_props u_props (.*);

// ---- sim/smpc_mem_model.sv ----
// External memory on the block's memory bus, decoded by the space selects.
`timescale 1ns/1ps
module smpc_mem_model (
    // Clock
    input wire logic clk,
    // Memory bus
    input wire logic [13:0] addr,
    input wire logic [23:0] dout,
    input wire logic [23:0] doe,
    input smpc_pkg::smpc_sel_s sel,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [23:0] din
);
    import smpc_pkg::*;
    logic [23:0] mem [64];
    logic [23:0] last_r;
    logic [5:0] key;
    assign key = {sel.dms_n, sel.pms_n, sel.io_space_select_n, addr[2:0]};
    // Floating bus shows the inverse of the last word read.
    assign din = (doe & dout) | (~doe & (!rd_n ? mem[key] : ~last_r));
    // Write on strobe; remember each word read.
    always_ff @(posedge clk) begin
        if (!wr_n) mem[key] <= dout;
        if (!rd_n) last_r <= mem[key];
    end
endmodule : smpc_mem_model

// ---- sim/testbench.sv ----
// Self-checking bench of the strap, mode and pin block.
`timescale 1ns/1ps
`include "smpc_defines.svh"
module testbench;
    import smpc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se, hmode, irq, ack_n, rd_n, wr_n;
    logic hwr_n, hrd_n, hal, hsel_n;
    logic [7:0] paddr, pf_in, pf_ext, pf_out, pf_oe;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] had, hout, hoe;
    logic [4:0] sp_in, sp_ext, sp_out, sp_oe;
    logic [5:0] ipend;
    logic [13:0] abus;
    logic [23:0] din, dout, doe;
    smpc_sel_s sel;
    int err_count, n_tests, cyc;
    // Pads: device drive over outside level.
    assign pf_in = (pf_oe & pf_out) | (~pf_oe & pf_ext);
    assign sp_in = (sp_oe & sp_out) | (~sp_oe & sp_ext);
    smpc_top dut (.prog_flag_in(pf_in), .prog_flag_out(pf_out), .prog_flag_oe(pf_oe), .fixed_output_flags(),
        .second_serial_port_in(sp_in), .second_serial_port_out(sp_out), .second_serial_port_oe(sp_oe),
        .sp_core_out(5'h00), .sp_core_oe(5'h00), .sp_core_in(), .ext_address_bus(abus),
        .ext_data_bus_in(din), .ext_data_bus_out(dout), .ext_data_bus_oe(doe), .space_select_n(sel),
        .mem_rd_n(rd_n), .mem_wr_n(wr_n), .host_port_addr_data_in(had), .host_port_addr_data_out(hout),
        .host_port_addr_data_oe(hoe), .host_port_write_en_n(hwr_n), .host_port_read_en_n(hrd_n),
        .host_port_addr_latch(hal), .host_port_select_n(hsel_n), .host_port_ack_n(ack_n),
        .host_mode(hmode), .irq_pending(ipend), .irq(irq), .*);
    smpc_mem_model u_mem (.clk(pclk), .addr(abus), .dout(dout), .doe(doe), .sel(sel), .rd_n(rd_n),
        .wr_n(wr_n), .din(din));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // One APB transfer after an idle edge; waits on pready.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic xwait;
        do apb(1'b0, `SMPC_OFF_EXT_CMD, 32'h0); while (r[0] !== 1'b0);
    endtask : xwait
    // Reset with straps, then the strap pins turn into flags.
    task automatic t_mode(input logic [2:0] s);
        presetn <= 1'b0;
        pf_ext[2:0] <= s;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        pf_ext[2:0] <= ~s;
        chk(hmode, s[2]);
        apb(1'b1, `SMPC_OFF_MODE, 32'h0);
        apb(1'b0, `SMPC_OFF_MODE, 32'h0);
        chk(r, {28'h0, s[2], s});
        apb(1'b0, `SMPC_OFF_FLAG_IN, 32'h0);
        chk(r[2:0] ^ s, 3'h7);
    endtask : t_mode
    // Every space in full mode; three read back.
    task automatic t_ext;
        logic [8:0] c = `SMPC_CTRL_RST;
        for (int sp = 0; sp < 4; sp++) begin
            apb(1'b1, `SMPC_OFF_EXT_ADDR, 32'h2a4000 | sp);
            apb(1'b1, `SMPC_OFF_EXT_WDATA, 32'h5a0f30 | sp);
            apb(1'b1, `SMPC_OFF_EXT_CMD, 32'h4 | sp);
            while (wr_n !== 1'b0) @(posedge pclk);
            chk(sel, {sp != 0, sp != 1, sp != 2, sp != 3, !c[5+sp]});
            chk(abus, sp);
            if (sp == 3) chk(dout[23:16], 8'ha9);
            xwait();
            if (sp < 3) begin
                apb(1'b1, `SMPC_OFF_EXT_CMD, sp);
                xwait();
                apb(1'b0, `SMPC_OFF_EXT_RDATA, 32'h0);
                chk(r, 32'h5a0f30 | sp);
            end
        end
        apb(1'b0, 8'h2c, 32'h0);
        chk({se, r}, 33'h100000000);
    endtask : t_ext
    // Masked event, then own flag drive interrupts.
    task automatic t_irq;
        apb(1'b1, `SMPC_OFF_IRQ_MASK, 32'h0);
        pf_ext[4] <= 1'b0;
        repeat (3) @(posedge pclk);
        pf_ext[4] <= 1'b1;
        chk(irq, 1'b0);
        apb(1'b0, `SMPC_OFF_IRQ_STAT, 32'h0);
        chk(r, 32'h8);
        apb(1'b1, `SMPC_OFF_IRQ_MASK, 32'h8);
        apb(1'b1, `SMPC_OFF_FLAG_OUT, 32'h0);
        apb(1'b1, `SMPC_OFF_FLAG_DIR, 32'h10);
        repeat (4) @(posedge pclk);
        chk({irq, ipend}, 7'h48);
        apb(1'b1, `SMPC_OFF_FLAG_DIR, 32'h0);
        apb(1'b0, `SMPC_OFF_IRQ_STAT, 32'h0);
        repeat (2) @(posedge pclk);
        chk({irq, r}, 33'h8);
    endtask : t_irq
    // Second serial port to flag mode and back while running.
    task automatic t_alt;
        apb(1'b1, `SMPC_OFF_CTRL, `SMPC_CTRL_RST | 32'h11);
        sp_ext[1] <= 1'b0;
        apb(1'b0, `SMPC_OFF_FLAG_IN, 32'h0);
        chk({sp_oe[4], sp_out[4], r[8]}, 3'h6);
        apb(1'b1, `SMPC_OFF_CTRL, `SMPC_CTRL_RST);
        repeat (2) @(posedge pclk);
        chk(sp_oe[4], 1'b0);
    endtask : t_alt
    // Host writes a word into the port and reads it back.
    task automatic t_host;
        hsel_n <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            hal <= 1'b1;
            had <= 16'h0005;
            @(posedge pclk);
            hal <= 1'b0;
            had <= k ? 16'ha5a5 : 16'h1234;
            hwr_n <= k[0];
            hrd_n <= !k[0];
            repeat (2) @(posedge pclk);
            chk(ack_n, 1'b0);
            if (k) chk({hoe, hout}, 32'hffff1234);
            {hwr_n, hrd_n} <= 2'b11;
            repeat (2) @(posedge pclk);
            chk(ack_n, 1'b1);
        end
        hsel_n <= 1'b1;
    endtask : t_host
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // A hang past the cycle ceiling counts as a mismatch.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, hal, paddr, pwdata, had} = '0;
        {hwr_n, hrd_n, hsel_n, pf_ext, sp_ext} = 16'hffff;
        @(posedge pclk);
        t_mode(3'b011);
        t_ext();
        t_irq();
        t_alt();
        t_mode(3'b101);
        t_host();
        end_sim();
    end
endmodule : testbench
